// >>> inc/sifl_defines.vh
// Purpose: constants for the servo input function logic
// Assumes: 40 MHz clock, AXI4-Lite register access
// Notes: offsets are byte addresses
`ifndef SIFL_DEFINES_VH
`define SIFL_DEFINES_VH
`define SIFL_NUM_IN 7
`define SIFL_FN_OFF 3'h0
`define SIFL_FN_FAULT_CLR 3'h1
`define SIFL_FN_START_TASK 3'h2
`define SIFL_FN_SEL_BIT 3'h3
`define SIFL_FN_START_SEL 3'h4
`define SIFL_OPMODE_POS 2'h2
`define SIFL_CMDSRC_SVC 2'h0
`define SIFL_UNIT_COUNTS 3'h0
`define SIFL_UNIT_RAD 3'h1
`define SIFL_UNIT_DEG 3'h2
`define SIFL_UNIT_CUSTOM 3'h3
`define SIFL_UNIT_CNT16 3'h4
`define SIFL_PITCH_MM 32'h0000_0020
`define SIFL_MICRON_PER_MM 32'h0000_03E8
`define SIFL_ADDR_FSEL 8'h00
`define SIFL_ADDR_ARG_BASE 8'h04
`define SIFL_ADDR_MODE 8'h20
`define SIFL_ADDR_STATUS 8'h24
`define SIFL_ADDR_UNIT 8'h28
`define SIFL_ADDR_SNUM 8'h2C
`define SIFL_ADDR_SDEN 8'h30
`define SIFL_ADDR_RES 8'h34
`define SIFL_ADDR_PITCH 8'h38
`define SIFL_ADDR_CTRL 8'h3C
`define SIFL_ADDR_POS 8'h40
`define SIFL_ADDR_POSUSR 8'h44
`define SIFL_CTRL_SAVE 0
`define SIFL_CTRL_DONE 1
`define SIFL_DEB_NS 32'h0000_2710
`define SIFL_CLK_NS 32'h0000_0019
`define SIFL_DEB_CYC ((`SIFL_DEB_NS + `SIFL_CLK_NS - 1) / `SIFL_CLK_NS)
`define SIFL_RESP_OKAY 2'h0
`define SIFL_RESP_SLVERR 2'h2
`endif

// >>> rtl/sifl_debounce.v
// Purpose: two-flop synchroniser, debounce, edge events for one input
// Assumes: asynchronous input pin
// Notes: level must hold stable for the debounce time
`timescale 1ns/10ps
`include "sifl_defines.vh"
module sifl_debounce (
  input wire mclk_in,
  input wire arst_n_in,
  input wire pin_in,
  output reg level_out,
  output reg rise_out,
  output reg fall_out
);
  reg sync_a;
  reg sync_b;
  reg [15:0] cnt;
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      cnt <= 16'h0000;
      level_out <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
      if (sync_b == level_out) begin
        cnt <= 16'h0000;
      end else if (cnt == `SIFL_DEB_CYC - 1) begin
        cnt <= 16'h0000;
        level_out <= sync_b;
        rise_out <= sync_b;
        fall_out <= ~sync_b;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule // sifl_debounce

// >>> rtl/sifl_top.v
// Purpose: digital input functions, unit selection and scaling registers
// Assumes: AXI4-Lite slave, one clock, inputs from external switches
// Notes: motion profile generator and fault logic sit outside
// Operation
// - code 0 does nothing, default everywhere
// - code 1 requests fault clear once per rise
// - code 2 starts task given by argument
// - codes 2 and 4 need position mode, service source
// - started task runs; its input ignored
// - any active task blocks all start inputs
// - code 3 inputs form binary task number
// - code 4 rising edge latches selected number
// - falling edge ignored; zero launches homing
// - native unit is 2^32 counts per rev
// - unit selector decodes five codes; only 16-bit counts rescale, others show raw counts
// - internal position always full 32 bits
// - cycles per pitch from scale resolution
// - scale numerator, denominator set from mechanics
// - units apply at once; save copies them
// - each input debounced
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "sifl_defines.vh"
module sifl_top (
  input wire mclk_in,
  input wire arst_n_in,
  input wire [6:0] din_in,
  input wire task_busy_in,
  input wire [31:0] position_in,
  input wire [31:0] mech_num_in,
  input wire [31:0] mech_den_in,
  input wire [3:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  output reg fault_clear_out,
  output reg task_start_out,
  output reg [6:0] task_number_out,
  output reg homing_start_out,
  output reg nv_save_out,
  output reg [2:0] unit_sel_out,
  output reg [31:0] scale_num_out,
  output reg [31:0] scale_ratio_denominator_out
);
  wire [6:0] lvl;
  wire [6:0] rise;
  wire [6:0] fall;
  reg [20:0] input_function_select;
  reg [6:0] input_function_argument [0:6];
  reg [1:0] opmode;
  reg [1:0] cmd_source;
  reg [31:0] scale_res;
  reg [31:0] pitch_cycles;
  reg [6:0] owner;
  reg running;
  reg [6:0] sel_num;
  reg [7:0] aw_addr;
  reg aw_have;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_have;
  reg [31:0] rd_val;
  reg rd_ok;
  reg [31:0] pos_user;
  reg [6:0] next_sel;
  reg next_clr;
  reg next_start;
  reg [6:0] next_num;
  reg [6:0] next_owner;
  integer i;
  integer j;
  genvar g;
  wire motion_ok = (opmode == `SIFL_OPMODE_POS) &&
    (cmd_source == `SIFL_CMDSRC_SVC);
  wire [7:0] waddr = aw_addr;
  wire do_write = aw_have && w_have && !s_axi_bvalid_out;

  generate
    for (g = 0; g < `SIFL_NUM_IN; g = g + 1) begin : g_in
      sifl_debounce u_deb (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .pin_in(din_in[g]),
        .level_out(lvl[g]),
        .rise_out(rise[g]),
        .fall_out(fall[g])
      );
    end
  endgenerate

  // input function decode
  always @* begin
    next_sel = 7'h00;
    next_clr = 1'b0;
    next_start = 1'b0;
    next_num = 7'h00;
    next_owner = 7'h00;
    for (i = 0; i < `SIFL_NUM_IN; i = i + 1) begin
      if (input_function_select[i*3 +: 3] == `SIFL_FN_SEL_BIT) begin
        next_sel = next_sel | ({6'h00, lvl[i]} << next_owner);
        next_owner = next_owner + 7'h01;
      end
    end
    next_owner = 7'h00;
    for (i = `SIFL_NUM_IN - 1; i >= 0; i = i - 1) begin
      case (input_function_select[i*3 +: 3])
        `SIFL_FN_FAULT_CLR: begin
          if (rise[i]) begin
            next_clr = 1'b1;
          end
        end
        `SIFL_FN_START_TASK: begin
          if (rise[i] && motion_ok && !running && !task_busy_in) begin
            next_start = 1'b1;
            next_num = input_function_argument[i];
            next_owner = 7'h01 << i;
          end
        end
        `SIFL_FN_START_SEL: begin
          if (rise[i] && motion_ok && !running && !task_busy_in) begin
            next_start = 1'b1;
            next_num = sel_num;
            next_owner = 7'h01 << i;
          end
        end
        default: begin
          next_clr = next_clr;
        end
      endcase
    end
  end

  // task control, select latch
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fault_clear_out <= 1'b0;
      task_start_out <= 1'b0;
      homing_start_out <= 1'b0;
      task_number_out <= 7'h00;
      running <= 1'b0;
      owner <= 7'h00;
      sel_num <= 7'h00;
    end else begin
      sel_num <= next_sel;
      fault_clear_out <= next_clr;
      task_start_out <= next_start && (next_num != 7'h00);
      homing_start_out <= next_start && (next_num == 7'h00);
      if (next_start) begin
        task_number_out <= next_num;
        running <= 1'b1;
        owner <= next_owner;
      end else if (running && !task_busy_in && !task_start_out &&
          !homing_start_out) begin
        running <= 1'b0;
        owner <= 7'h00;
      end
    end
  end

  // presentation of position in chosen unit
  always @* begin
    case (unit_sel_out)
      `SIFL_UNIT_COUNTS: pos_user = position_in;
      `SIFL_UNIT_CNT16: pos_user = {16'h0000, position_in[31:16]};
      `SIFL_UNIT_DEG: pos_user = position_in;
      `SIFL_UNIT_RAD: pos_user = position_in;
      `SIFL_UNIT_CUSTOM: pos_user = position_in;
      default: pos_user = position_in;
    endcase
  end

  // register write path
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `SIFL_RESP_OKAY;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      input_function_select <= 21'h00_0000;
      for (j = 0; j < `SIFL_NUM_IN; j = j + 1) begin
        input_function_argument[j] <= 7'h00;
      end
      opmode <= 2'h0;
      cmd_source <= 2'h0;
      unit_sel_out <= `SIFL_UNIT_COUNTS;
      scale_num_out <= 32'h0000_0001;
      scale_ratio_denominator_out <= 32'h0000_0001;
      scale_res <= 32'h0000_0001;
      pitch_cycles <= 32'h0000_0000;
      nv_save_out <= 1'b0;
    end else begin
      nv_save_out <= 1'b0;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_addr <= {4'h0, s_axi_awaddr_in} << 2;
        aw_have <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
        w_have <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= `SIFL_RESP_OKAY;
        if (waddr == `SIFL_ADDR_FSEL && w_strb[0]) begin
          input_function_select <= w_data[20:0];
        end else if (waddr >= `SIFL_ADDR_ARG_BASE &&
            waddr < `SIFL_ADDR_MODE) begin
          input_function_argument[waddr[4:2] - 3'h1] <= w_data[6:0];
        end else if (waddr == `SIFL_ADDR_MODE) begin
          opmode <= w_data[1:0];
          cmd_source <= w_data[5:4];
        end else if (waddr == `SIFL_ADDR_UNIT) begin
          unit_sel_out <= w_data[2:0];
        end else if (waddr == `SIFL_ADDR_RES) begin
          scale_res <= w_data;
          pitch_cycles <= (`SIFL_MICRON_PER_MM * `SIFL_PITCH_MM) /
            ((w_data == 32'h0000_0000) ? 32'h0000_0001 : w_data);
        end else if (waddr == `SIFL_ADDR_CTRL) begin
          if (w_data[`SIFL_CTRL_DONE]) begin
            scale_num_out <= mech_num_in;
            scale_ratio_denominator_out <= mech_den_in;
          end
          nv_save_out <= w_data[`SIFL_CTRL_SAVE];
        end else begin
          s_axi_bresp_out <= `SIFL_RESP_SLVERR;
        end
      end
    end
  end

  // register read path
  always @* begin
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr_in)
      `SIFL_ADDR_FSEL: rd_val = {11'h000, input_function_select};
      `SIFL_ADDR_MODE: rd_val = {26'h000_0000, cmd_source, 2'h0, opmode};
      `SIFL_ADDR_STATUS: rd_val = {7'h00, owner, task_number_out,
        sel_num, 1'b0, running, lvl[1:0]};
      `SIFL_ADDR_UNIT: rd_val = {29'h0000_0000, unit_sel_out};
      `SIFL_ADDR_SNUM: rd_val = scale_num_out;
      `SIFL_ADDR_SDEN: rd_val = scale_ratio_denominator_out;
      `SIFL_ADDR_RES: rd_val = scale_res;
      `SIFL_ADDR_PITCH: rd_val = pitch_cycles;
      `SIFL_ADDR_POS: rd_val = position_in;
      `SIFL_ADDR_POSUSR: rd_val = pos_user;
      default: begin
        if (s_axi_araddr_in >= `SIFL_ADDR_ARG_BASE &&
            s_axi_araddr_in < `SIFL_ADDR_MODE &&
            s_axi_araddr_in[1:0] == 2'h0) begin
          rd_val = {25'h000_0000,
            input_function_argument[s_axi_araddr_in[4:2] - 3'h1]};
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `SIFL_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_val;
      s_axi_rresp_out <= rd_ok ? `SIFL_RESP_OKAY : `SIFL_RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end
endmodule // sifl_top

// >>> tb/sifl_top_asserts.sv
// Purpose: port checks for sifl_top
// Assumes: one clock, async low reset
// Notes: bound to every sifl_top
`timescale 1ns/10ps
module sifl_top_chk (
  input wire mclk_in,
  input wire arst_n_in,
  input wire task_busy_in,
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire s_axi_rvalid_out,
  input wire [1:0] s_axi_rresp_out,
  input wire fault_clear_out,
  input wire task_start_out,
  input wire [6:0] task_number_out,
  input wire homing_start_out,
  input wire nv_save_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_wr_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out;
  endsequence
  sequence s_rd_bad;
    s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in > 8'h44;
  endsequence
  property p_fc_once; fault_clear_out |=> !fault_clear_out; endproperty
  a_fc_once: assert property (p_fc_once)
    else $error("fault clear held");
  property p_ts_once; task_start_out |=> !task_start_out; endproperty
  a_ts_once: assert property (p_ts_once)
    else $error("task start held");
  property p_hs_once; homing_start_out |=> !homing_start_out; endproperty
  a_hs_once: assert property (p_hs_once)
    else $error("homing start held");
  property p_sv_once; nv_save_out |=> !nv_save_out; endproperty
  a_sv_once: assert property (p_sv_once)
    else $error("save held");
  property p_task_nz;
    task_start_out |-> !homing_start_out ##[0:1] task_number_out != 7'h00;
  endproperty
  a_task_nz: assert property (p_task_nz)
    else $error("stored task with number zero");
  property p_busy_block;
    task_busy_in [*3] |=> !task_start_out && !homing_start_out;
  endproperty
  a_busy_block: assert property (p_busy_block)
    else $error("start while busy");
  property p_wr_resp; s_wr_taken |-> ##[1:3] s_axi_bvalid_out; endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("no write response");
  property p_rd_bad;
    s_rd_bad |=> s_axi_rvalid_out && s_axi_rresp_out == 2'h2;
  endproperty
  a_rd_bad: assert property (p_rd_bad)
    else $error("unmapped read not refused");
endmodule // sifl_top_chk
bind sifl_top sifl_top_chk chk_i (.*);

// >>> tb/sifl_switch_model.sv
// Purpose: bouncing switch bank on the digital inputs
// Assumes: bounce far shorter than debounce time
// Notes: level held long after settling
`timescale 1ns/10ps
module sifl_switch_model (
  input wire mclk_in,
  output reg [6:0] din_out
);
  initial din_out = 7'h00;
  task flip(input integer idx, input reg lvl);
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        @(posedge mclk_in);
        din_out[idx] <= lvl ^ k[0];
        repeat (20) @(posedge mclk_in);
      end
      @(posedge mclk_in);
      din_out[idx] <= lvl;
      repeat (500) @(posedge mclk_in);
    end
  endtask
endmodule // sifl_switch_model

// >>> tb/sifl_top_tb.sv
// Purpose: self-checking bench for sifl_top
// Assumes: 40 MHz clock, bouncing switches
// Notes: pulses counted, registers over axi4-lite
`timescale 1ns/10ps
`include "sifl_defines.vh"
module sifl_top_tb;
  reg mclk_in = 1'b0;
  reg arst_n_in = 1'b0;
  reg task_busy_in = 1'b0;
  reg [31:0] position_in = 32'h1234_5678;
  reg [31:0] mech_num_in = 32'h0000_0002;
  reg [31:0] mech_den_in = 32'h0000_0005;
  reg [3:0] s_axi_awaddr_in = 4'h0;
  reg s_axi_awvalid_in = 1'b0;
  reg [31:0] s_axi_wdata_in = 32'h0000_0000;
  reg [3:0] s_axi_wstrb_in = 4'hF;
  reg s_axi_wvalid_in = 1'b0;
  reg s_axi_bready_in = 1'b0;
  reg [7:0] s_axi_araddr_in = 8'h00;
  reg s_axi_arvalid_in = 1'b0;
  reg s_axi_rready_in = 1'b0;
  wire [6:0] din_in;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  wire s_axi_arready_out, s_axi_rvalid_out, fault_clear_out;
  wire task_start_out, homing_start_out, nv_save_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out, scale_num_out, scale_ratio_denominator_out;
  wire [6:0] task_number_out;
  wire [2:0] unit_sel_out;
  integer errors = 0;
  integer comparisons = 0;
  integer n_fc = 0, n_ts = 0, n_hs = 0, n_sv = 0, u;
  reg [31:0] q;
  reg [1:0] r;
  sifl_top dut (.*);
  sifl_switch_model sw (.mclk_in(mclk_in), .din_out(din_in));
  initial forever #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    if (fault_clear_out === 1'b1) n_fc <= n_fc + 1;
    if (task_start_out === 1'b1) n_ts <= n_ts + 1;
    if (homing_start_out === 1'b1) n_hs <= n_hs + 1;
    if (nv_save_out === 1'b1) n_sv <= n_sv + 1;
  end
  task chk(input [8*6:1] nm, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge mclk_in);
      s_axi_awaddr_in <= a[5:2];
      s_axi_awvalid_in <= 1'b1;
      s_axi_wdata_in <= d;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      t = 0;
      while (t < 40) begin
        @(posedge mclk_in);
        t = t + 1;
        if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
        if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        if (s_axi_bvalid_out) begin
          r = s_axi_bresp_out;
          s_axi_bready_in <= 1'b0;
          t = 99;
        end
      end
      chk("bwait", 99, t);
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    integer t;
    begin
      @(posedge mclk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      t = 0;
      while (t < 40) begin
        @(posedge mclk_in);
        t = t + 1;
        if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        if (s_axi_rvalid_out) begin
          d = s_axi_rdata_out;
          r = s_axi_rresp_out;
          s_axi_rready_in <= 1'b0;
          t = 99;
        end
      end
      chk("rwait", 99, t);
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (40000) @(posedge mclk_in);
    errors = errors + 1;
    print_verdict;
  end
  initial begin
    repeat (3) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    chk("usel", 0, unit_sel_out);
    chk("sden", 1, scale_ratio_denominator_out);
    rd(8'h00, q);
    chk("fsel", 0, q);
    rd(8'h80, q);
    chk("resp", 2, r);
    wr(8'h00, 32'h0000_0011);
    sw.flip(0, 1);
    sw.flip(0, 0);
    sw.flip(0, 1);
    chk("fc", 2, n_fc);
    wr(8'h08, 32'h0000_0005);
    sw.flip(1, 1);
    wr(8'h20, 32'h0000_0012);
    sw.flip(1, 0);
    sw.flip(1, 1);
    chk("ts", 0, n_ts);
    wr(8'h20, 32'h0000_0002);
    sw.flip(1, 0);
    sw.flip(1, 1);
    chk("ts", 1, n_ts);
    chk("tnum", 5, task_number_out);
    task_busy_in <= 1'b1;
    sw.flip(1, 0);
    sw.flip(1, 1);
    chk("ts", 1, n_ts);
    wr(8'h00, 32'h0002_36D1);
    sw.flip(5, 1);
    chk("hs", 0, n_hs);
    task_busy_in <= 1'b0;
    sw.flip(5, 0);
    sw.flip(3, 1);
    sw.flip(4, 1);
    sw.flip(5, 1);
    chk("tnum", 6, task_number_out);
    sw.flip(5, 0);
    chk("ts", 2, n_ts);
    sw.flip(3, 0);
    sw.flip(4, 0);
    sw.flip(5, 1);
    chk("hs", 1, n_hs);
    for (u = 0; u < 5; u = u + 1) begin
      wr(8'h28, u);
      chk("usel", u, unit_sel_out);
    end
    rd(8'h40, q);
    chk("pos", 32'h1234_5678, q);
    rd(8'h44, q);
    chk("pos16", 32'h0000_1234, q);
    wr(8'h3C, 32'h0000_0001);
    wr(8'h34, 32'h0000_0028);
    chk("save", 1, n_sv);
    rd(8'h38, q);
    chk("pitch", 32'h0000_0320, q);
    wr(8'h3C, 32'h0000_0002);
    chk("bresp", 0, r);
    chk("snum", 2, scale_num_out);
    chk("sden", 5, scale_ratio_denominator_out);
    wr(8'h2C, 32'h0000_0009);
    chk("bresp", 2, r);
    rd(8'h2C, q);
    chk("snumr", 2, q);
    rd(8'h30, q);
    chk("sdenr", 5, q);
    rd(8'h24, q);
    chk("stat", 32'h0000_0003, q);
    print_verdict;
  end
endmodule // sifl_top_tb
